// File: plsr_pkg.sv
// plsr_pkg: constants and carrier types for the parallel-load shift register
// assumes: included before plsr_core; one 10 MHz system clock
package plsr_pkg;

	// ----------------------------------------------------------------
	// register shape
	// ----------------------------------------------------------------
	localparam int          PLSR_STAGES     = 8;
	localparam int          PLSR_LAST_STAGE = PLSR_STAGES - 1;
	localparam logic [7:0]  PLSR_CLEAR_VAL  = 8'h00;

	// ----------------------------------------------------------------
	// timing and reset values
	// ----------------------------------------------------------------
	localparam int          PLSR_CLK_PERIOD_NS = 100;
	// internal clock is taken as high at reset so no edge is invented
	localparam logic        PLSR_NOR_RESET_VAL = 1'b1;
	localparam logic        PLSR_OUT_RESET_VAL = 1'b0;

	typedef logic [PLSR_STAGES-1:0] plsr_stages_t;

	// pin group driven by the system logic
	typedef struct packed {
		logic shiftClk;       // clock pin
		logic clockInhibit;   // second nor input
		logic shiftNotLoad;   // high shift, low load
		logic serialIn;       // serial data into first stage
	} plsr_ctrl_s;

	typedef enum logic {
		PLSR_MODE_LOAD,
		PLSR_MODE_SHIFT
	} plsr_mode_e;

endpackage

// File: plsr_core.sv
// plsr_core: eight-stage parallel-in or serial-in, serial-out shift register
// assumes: all pins except asyncClearN synchronous to clk; pin clock is far slower than clk
`timescale 1ns/10ps

module plsr_core
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// pins from the system logic
	input  wire plsr_pkg::plsr_ctrl_s ctrl,
	input  wire plsr_pkg::plsr_stages_t parallelIn,
	input  wire logic               asyncClearN,
	// serial result
	output logic                    serialOut
);
	import plsr_pkg::*;

	// pins are sampled on clk and the gated clock is rebuilt from its sampled level,
	// so an effective edge lands on the first clk edge that sees the nor gate open

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	// effective clock level seen by the stages
	function automatic logic internalClock(input plsr_ctrl_s c);
		internalClock = ~(c.shiftClk | c.clockInhibit);
	endfunction

	function automatic plsr_mode_e modeOf(input plsr_ctrl_s c);
		modeOf = c.shiftNotLoad ? PLSR_MODE_SHIFT : PLSR_MODE_LOAD;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	plsr_stages_t stages_reg;
	plsr_stages_t stages_next;
	plsr_stages_t shifted;
	logic         norPrev_reg;
	logic         norPrev_next;
	logic         serialOut_reg;
	logic         serialOut_next;
	logic         clockEdge;
	logic         nowNor;

	assign nowNor    = internalClock(ctrl);
	// rising edge of the gated clock; a high on either input keeps it low
	assign clockEdge = nowNor & ~norPrev_reg;

	// shift chain: each stage after the first takes its predecessor; the first takes serialIn
	assign shifted[0] = ctrl.serialIn;
	generate
		for (genvar i = 1; i < PLSR_STAGES; i++)
		begin : g_chain
			assign shifted[i] = stages_reg[i-1];
		end
	endgenerate

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	// pick the stage update; hold when no effective edge
	always_comb
	begin
		stages_next  = stages_reg;
		if (!asyncClearN)
		begin
			stages_next = PLSR_CLEAR_VAL;
		end
		else if (clockEdge)
		begin
			case (modeOf(ctrl))
				PLSR_MODE_SHIFT: stages_next = shifted;
				PLSR_MODE_LOAD:  stages_next = parallelIn;
				default:         stages_next = stages_reg;
			endcase
		end
		serialOut_next = stages_next[PLSR_LAST_STAGE];
	end

	// edge tracker: next value is the gated clock level seen now
	always_comb
	begin
		norPrev_next = nowNor;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// clear acts without the clock and overrides every load and shift
	// clear sits in the sensitivity list so stages drop without waiting for clk
	always_ff @(posedge clk or negedge resetn or negedge asyncClearN)
	begin
		if (!resetn || !asyncClearN)
		begin
			stages_reg    <= PLSR_CLEAR_VAL;
			serialOut_reg <= PLSR_OUT_RESET_VAL;
		end
		else
		begin
			stages_reg    <= stages_next;
			serialOut_reg <= serialOut_next;
		end
	end

	// edge tracker keeps running through a clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			norPrev_reg <= PLSR_NOR_RESET_VAL;
		else
			norPrev_reg <= norPrev_next;
	end

	assign serialOut = serialOut_reg;

	// ----------------------------------------------------------------
	// assertions: data path
	// ----------------------------------------------------------------
	// output is the registered copy of the last stage
	AST_OUT_LAST_STAGE: assert property (@(posedge clk) disable iff (!resetn)
		serialOut == stages_reg[PLSR_LAST_STAGE])
		else $error("serial output differs from last stage");

	// a shift moves the whole chain one place
	AST_SHIFT_ONE: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(clockEdge && ctrl.shiftNotLoad) |=>
		stages_reg[PLSR_STAGES-1:1] == $past(stages_reg[PLSR_STAGES-2:0]))
		else $error("shift did not move stages by one");

	// each stage after the first takes its own predecessor on a shift
	generate
		for (genvar j = 1; j < PLSR_STAGES; j++)
		begin : g_chain_check
			AST_STAGE_STEP: assert property (@(posedge clk)
				disable iff (!resetn || !asyncClearN)
				(clockEdge && ctrl.shiftNotLoad) |=> stages_reg[j] == $past(stages_reg[j-1]))
				else $error("a stage did not take its predecessor");
		end
	endgenerate

	// on a shift the old next-to-last stage appears on the output
	AST_SHIFT_OUT: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(clockEdge && ctrl.shiftNotLoad) |=> serialOut == $past(stages_reg[PLSR_LAST_STAGE-1]))
		else $error("serial output did not take the next stage");

	// the serial bit enters the first stage on a shift
	AST_SERIAL_ENTRY: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(clockEdge && ctrl.shiftNotLoad) |=> stages_reg[0] == $past(ctrl.serialIn))
		else $error("first stage did not take serial input");

	// a load copies the whole parallel word on the edge
	AST_LOAD_ON_EDGE: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(clockEdge && !ctrl.shiftNotLoad) |=> stages_reg == $past(parallelIn))
		else $error("parallel load did not capture inputs");

	// the loaded top bit shows on the output right after the edge
	AST_LOAD_OUT: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(clockEdge && !ctrl.shiftNotLoad) |=> serialOut == $past(parallelIn[PLSR_LAST_STAGE]))
		else $error("serial output did not show the loaded top bit");

	// a differing serial bit must not reach the first stage on a load
	AST_LOAD_IGNORES_SERIAL: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(clockEdge && !ctrl.shiftNotLoad && ctrl.serialIn != parallelIn[0]) |=>
		stages_reg[0] != $past(ctrl.serialIn))
		else $error("serial input leaked into a load");

	// without an effective edge the stages hold
	AST_HOLD_NO_EDGE: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		!clockEdge |=> $stable(stages_reg))
		else $error("stages changed without an effective edge");

	// ----------------------------------------------------------------
	// assertions: clocking and clear
	// ----------------------------------------------------------------
	// a gated clock that stays high gives no edge
	AST_NO_UPDATE_HIGH_NOR: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(nowNor && norPrev_reg) |=> $stable(stages_reg))
		else $error("stages changed without a rising internal edge");

	// either clock input high keeps the stages frozen
	AST_INHIBIT_BLOCKS: assert property (@(posedge clk) disable iff (!resetn || !asyncClearN)
		(ctrl.shiftClk || ctrl.clockInhibit) |=> $stable(stages_reg))
		else $error("stages changed while clocking was blocked");

	// clear holds every stage and the output at zero
	AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (!resetn)
		!asyncClearN |-> (stages_reg == PLSR_CLEAR_VAL && !serialOut))
		else $error("clear did not hold stages at zero");

	// an effective edge during clear changes nothing
	AST_CLEAR_BEATS_EDGE: assert property (@(posedge clk) disable iff (!resetn)
		(!asyncClearN && clockEdge) |=> stages_reg == PLSR_CLEAR_VAL)
		else $error("an edge got through a clear");

	// stages are still empty when clear lets go
	AST_CLEAR_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
		$rose(asyncClearN) |-> (stages_reg == PLSR_CLEAR_VAL && !serialOut))
		else $error("stages not empty when clear let go");

	// ----------------------------------------------------------------
	// cover points
	// ----------------------------------------------------------------
	// shift, load, clear over data, pin clock low while inhibit blocks, serial bit refused
	COV_SHIFT: cover property (@(posedge clk) disable iff (!resetn)
		clockEdge && ctrl.shiftNotLoad && asyncClearN);
	COV_LOAD: cover property (@(posedge clk) disable iff (!resetn)
		clockEdge && !ctrl.shiftNotLoad && asyncClearN);
	COV_CLEAR_AFTER_DATA: cover property (@(posedge clk) disable iff (!resetn)
		(stages_reg != PLSR_CLEAR_VAL) ##1 !asyncClearN);
	COV_INHIBITED_CLOCK: cover property (@(posedge clk) disable iff (!resetn)
		ctrl.clockInhibit && !ctrl.shiftClk);
	COV_SERIAL_IGNORED: cover property (@(posedge clk) disable iff (!resetn)
		clockEdge && !ctrl.shiftNotLoad && ctrl.serialIn != parallelIn[0] && asyncClearN);

endmodule // plsr_core

// File: plsr_sys_model.sv
// plsr_sys_model: system logic that drives the register pins
// assumes: clk from the bench; pins change on its falling edge
`timescale 1ns/10ps
module plsr_sys_model
(
	// clock
	input  wire logic             clk,
	// pins to the register
	output plsr_pkg::plsr_ctrl_s  ctrl,
	output plsr_pkg::plsr_stages_t parallelIn,
	output logic                  asyncClearN
);
	import plsr_pkg::*;
	// idle: both clock inputs high, so the nor stays low
	initial
	begin
		ctrl = '{1'b1, 1'b1, 1'b1, 1'b0};
		parallelIn = 8'h00;
		asyncClearN = 1'b1;
	end
	// one effective edge through the pin or the inhibit, gap slows it
	task automatic pulse(input logic useInh, input logic sh, input logic serial_in,
		input plsr_stages_t par, input int gap);
		@(negedge clk);
		ctrl.shiftNotLoad = sh;
		ctrl.serialIn = serial_in;
		parallelIn = par;
		// the held-low input drops first; the other one then acts as the clock
		if (useInh)
			ctrl.shiftClk = 1'b0;
		else
			ctrl.clockInhibit = 1'b0;
		repeat (gap) @(negedge clk);
		if (useInh)
			ctrl.clockInhibit = 1'b0; // nor rises
		else
			ctrl.shiftClk = 1'b0; // nor rises
		@(negedge clk);
		ctrl.shiftClk = 1'b1;
		@(negedge clk);
		ctrl.clockInhibit = 1'b1; // pin already high
	endtask
	// toggle each clock input while the other one blocks
	task automatic stray(input plsr_stages_t par);
		@(negedge clk);
		ctrl.shiftNotLoad = 1'b0;
		parallelIn = par;
		ctrl.shiftClk = 1'b0;
		@(negedge clk);
		ctrl.shiftClk = 1'b1;
		ctrl.clockInhibit = 1'b0;
		@(negedge clk);
		ctrl.clockInhibit = 1'b1;
	endtask
	task automatic clear(input logic lvl);
		@(negedge clk);
		asyncClearN = lvl;
	endtask
endmodule // plsr_sys_model

// File: tb_top.sv
// tb_top: self-checking bench for plsr_core
// assumes: plsr_pkg, plsr_core and plsr_sys_model compiled first
`timescale 1ns/10ps
module tb_top;
	import plsr_pkg::*;
	logic         clk = 1'b0;
	logic         resetn = 1'b0;
	plsr_ctrl_s   ctrl;
	plsr_stages_t parallelIn;
	logic         asyncClearN;
	logic         serialOut;
	int           bad_count = 0;
	int           n_compared = 0;
	// 10 MHz clock
	initial forever #(PLSR_CLK_PERIOD_NS / 2) clk = ~clk;
	plsr_sys_model u_plsr_sys_model (.clk(clk), .ctrl(ctrl),
		.parallelIn(parallelIn), .asyncClearN(asyncClearN));
	plsr_core u_plsr_core (.clk(clk), .resetn(resetn), .ctrl(ctrl),
		.parallelIn(parallelIn), .asyncClearN(asyncClearN), .serialOut(serialOut));
	task automatic check(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// load with serial input high, shift out with shrinking delays
	task automatic load_shift();
		logic [7:0] w;
		w = 8'hA4;
		u_plsr_sys_model.pulse(1'b0, 1'b0, 1'b1, w, 0);
		check(serialOut, w[7]);
		for (int i = 6; i >= 0; i--)
		begin
			u_plsr_sys_model.pulse(1'b0, 1'b1, 1'b0, 8'hFF, i);
			check(serialOut, w[i]);
		end
	endtask
	// clock through the inhibit: first one in leaves after eight
	task automatic inhibit_clock();
		for (int k = 1; k <= 8; k++)
		begin
			u_plsr_sys_model.pulse(1'b1, 1'b1, 1'b1, 8'h00, 0);
			check(serialOut, k == 8);
		end
	endtask
	// blocked toggles must not load the zeros
	task automatic blocked();
		u_plsr_sys_model.stray(8'h00);
		repeat (2) @(negedge clk);
		check(serialOut, 1'b1);
	endtask
	// clear acts at once and beats a load edge
	task automatic clear_all();
		u_plsr_sys_model.clear(1'b0);
		#1;
		check(serialOut, 1'b0);
		u_plsr_sys_model.pulse(1'b0, 1'b0, 1'b0, 8'hFF, 0);
		check(serialOut, 1'b0);
		u_plsr_sys_model.clear(1'b1);
		u_plsr_sys_model.pulse(1'b0, 1'b0, 1'b0, 8'h80, 0);
		check(serialOut, 1'b1);
	endtask
	// reset in mid-run empties the stages and the next load still lands
	task automatic reset_mid();
		@(negedge clk);
		resetn = 1'b0;
		#1;
		check(serialOut, 1'b0);
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		u_plsr_sys_model.pulse(1'b0, 1'b0, 1'b1, 8'h80, 0);
		check(serialOut, 1'b1);
	endtask
	// watchdog
	initial
	begin
		#(2000 * PLSR_CLK_PERIOD_NS);
		bad_count++;
		conclude();
	end
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		check(serialOut, 1'b0);
		load_shift();
		inhibit_clock();
		blocked();
		clear_all();
		reset_mid();
		conclude();
	end
endmodule // tb_top
